//--- aff_ram.sv
// Affinity storage with registered read data
`timescale 1ns/1ps
module aff_ram #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire core_removal_pkg::aff_type wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output core_removal_pkg::aff_type rdata
);
  import core_removal_pkg::*;

  aff_type mem [DEPTH];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule : aff_ram

//--- core_removal_pkg.sv
// Constants and types shared by the core removal and redistributor remap logic
package core_removal_pkg;

  // Build path choice
  typedef enum logic {REMOVE_BY_STRAP, REMOVE_BY_PROG} path_type;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] CFG_OFS = 12'h004;
  localparam logic [11:0] COUNT_OFS = 12'h008;
  localparam logic [11:0] AUX_OFS = 12'h00c;
  localparam logic [11:0] REMOVE_FIRST_OFS = 12'h040;
  localparam logic [11:0] REMOVE_LAST_OFS = 12'h07c;
  localparam logic [11:0] SEL_OFS = 12'h100;
  localparam logic [11:0] AFF_OFS = 12'h104;
  localparam logic [11:0] TYPE_OFS = 12'h108;
  localparam logic [11:0] ERRINS_OFS = 12'h10c;
  localparam logic [11:0] ERRREC_OFS = 12'h110;

  // Field positions
  localparam int SECDIS_BIT = 0;
  localparam int CAPABLE_BIT = 0;
  localparam int VIEW_BIT = 1;
  localparam int FINAL_BIT = 0;
  localparam int PPI_LSB = 8;
  localparam int PROC_LSB = 16;
  localparam int ERRREC_VALID_BIT = 31;
  localparam int PPROT_NONSEC_BIT = 1;

  // Removal word geometry: sixteen words of 32 bits, one 32-core word per register
  localparam int REMOVE_WORD_BITS = 32;
  localparam int REMOVE_WORDS = 16;
  localparam int AFF_FIELD_W = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // One redistributor affinity, four levels
  typedef struct packed {
    logic [AFF_FIELD_W-1:0] level3;
    logic [AFF_FIELD_W-1:0] level2;
    logic [AFF_FIELD_W-1:0] level1;
    logic [AFF_FIELD_W-1:0] level0;
  } aff_type;

endpackage : core_removal_pkg

//--- core_removal_remap.sv
// Core removal, redistributor compaction and affinity remap with APB registers
`timescale 1ns/1ps

// Operation
// - Build parameter selects removal by software registers or by reset-sampled tie-offs.
// - Software removal needs a secure access unless security-disable flag is set.
// - With multiple views, only view 0 may remove cores or program affinity.
// - Read-only capability flag reads 1 when software removal is supported.
// - Removal words cover 32 cores per register; writing 1 removes that core.
// - Remaining cores shift down to lower slots and, in the programmable build, inherit the affinity slots of removed ones.
// - Remaining redistributors appear as one contiguous block without gaps.
// - Strap removal is applied while leaving reset, invisible to software.
// - Tie-off bit 1 removes a core; integrator never sets all bits.
// - Four affinity tie-off buses, one slice per core per level.
// - A tie-off of zero computed width is absent from the instance; here it keeps one bit per core and is ignored.
// - Tie-off bit order follows default redistributor page order.
// - Final-redistributor flag moves to the last remaining redistributor.
// - Auxiliary distributor page moves directly above the last remaining one.
// - Removed cores get no error insertion and no RAM error reports.
// - Self-test interface is untouched by removal.
// - Private interrupt count field comes straight from a tie-off.
module core_removal_remap #(
  parameter core_removal_pkg::path_type PATH = core_removal_pkg::REMOVE_BY_PROG,
  parameter bit MULTI_VIEW = 1'b0,
  parameter int NUM_CORES = 16,
  parameter int AFF0_W = 2,
  parameter int AFF1_W = 2,
  parameter int AFF2_W = 2,
  parameter int AFF3_W = 0,
  localparam int IDXW = (NUM_CORES > 1) ? $clog2(NUM_CORES) : 1,
  localparam int T0W = (AFF0_W > 0) ? AFF0_W : 1,
  localparam int T1W = (AFF1_W > 0) ? AFF1_W : 1,
  localparam int T2W = (AFF2_W > 0) ? AFF2_W : 1,
  localparam int T3W = (AFF3_W > 0) ? AFF3_W : 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] pprot,
  input wire logic [1:0] access_view,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Integrator tie-offs
  input wire logic [NUM_CORES-1:0] core_remove_tieoff,
  input wire logic [NUM_CORES*T0W-1:0] level_zero_aff_tieoff,
  input wire logic [NUM_CORES*T1W-1:0] level_one_aff_tieoff,
  input wire logic [NUM_CORES*T2W-1:0] level_two_aff_tieoff,
  input wire logic [NUM_CORES*T3W-1:0] level_three_aff_tieoff,
  input wire logic [7:0] ppi_count_tieoff,
  // RAM error reports from cluster interfaces
  input wire logic ram_err_valid,
  input wire logic [IDXW-1:0] ram_err_core,
  // Remap results
  output logic [IDXW:0] remaining_count,
  output logic [IDXW:0] aux_page_index,
  output logic [IDXW-1:0] route_phys_core,
  output logic err_inject_valid,
  output logic [IDXW-1:0] err_inject_core,
  output logic [31:0] err_inject_data
);
  import core_removal_pkg::*;

  if (NUM_CORES < 2 || NUM_CORES > REMOVE_WORDS * REMOVE_WORD_BITS) begin : g_bad_cores
    $error("core count out of range");
  end
  if (AFF0_W > AFF_FIELD_W || AFF1_W > AFF_FIELD_W ||
      AFF2_W > AFF_FIELD_W || AFF3_W > AFF_FIELD_W) begin : g_bad_aff
    $error("affinity width above field width");
  end

  //////////////////////////////////////////////////////////////////////////////
  // State
  logic [31:0] ctrl;
  logic [NUM_CORES-1:0] removed;
  logic [NUM_CORES-1:0] written;
  logic strap_taken;
  logic [IDXW-1:0] sel;
  logic [31:0] err_record;
  aff_type ram_rdata;

  //////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire setup = psel & ~penable;
  wire access = psel & penable & ~pready;
  wire done = psel & penable & pready;
  wire wr_done = done & pwrite;
  wire secure_ok = ~pprot[PPROT_NONSEC_BIT] | ctrl[SECDIS_BIT];
  wire view_ok = ~MULTI_VIEW | (access_view == 2'b00);
  wire prog_path = (PATH == REMOVE_BY_PROG);
  wire remap_ok = prog_path & secure_ok & view_ok;
  wire hit_ctrl = (paddr == CTRL_OFS);
  wire hit_cfg = (paddr == CFG_OFS);
  wire hit_count = (paddr == COUNT_OFS);
  wire hit_aux = (paddr == AUX_OFS);
  wire hit_remove = (paddr >= REMOVE_FIRST_OFS) && (paddr <= REMOVE_LAST_OFS) &&
                    (paddr[1:0] == 2'b00);
  wire hit_sel = (paddr == SEL_OFS);
  wire hit_aff = (paddr == AFF_OFS);
  wire hit_type = (paddr == TYPE_OFS);
  wire hit_errins = (paddr == ERRINS_OFS);
  wire hit_errrec = (paddr == ERRREC_OFS);
  wire mapped = hit_ctrl | hit_cfg | hit_count | hit_aux | hit_remove | hit_sel |
                hit_aff | hit_type | hit_errins | hit_errrec;
  wire [11:0] remove_rel = paddr - REMOVE_FIRST_OFS;
  wire [3:0] remove_word = remove_rel[5:2];

  //////////////////////////////////////////////////////////////////////////////
  // Compaction: count survivors, route compacted index to physical core
  logic [IDXW:0] next_count;
  logic [IDXW-1:0] sel_phys;
  logic sel_phys_found;
  logic [IDXW:0] seen;

  always_comb begin
    next_count = '0;
    sel_phys = '0;
    sel_phys_found = 1'b0;
    seen = '0;
    for (int i = 0; i < NUM_CORES; i++) begin
      if (!removed[i]) begin
        if (!sel_phys_found && seen == {1'b0, sel}) begin
          sel_phys = IDXW'(i);
          sel_phys_found = 1'b1;
        end
        seen = seen + 1'b1;
      end
    end
    next_count = seen;
  end

  wire sel_is_final = ({1'b0, sel} == remaining_count - 1'b1);
  wire sel_in_range = ({1'b0, sel} < remaining_count);

  //////////////////////////////////////////////////////////////////////////////
  // Affinity of the selected slot
  wire [AFF_FIELD_W-1:0] tie0 = (AFF0_W > 0) ?
    AFF_FIELD_W'(level_zero_aff_tieoff[sel_phys*T0W +: T0W]) : '0;
  wire [AFF_FIELD_W-1:0] tie1 = (AFF1_W > 0) ?
    AFF_FIELD_W'(level_one_aff_tieoff[sel_phys*T1W +: T1W]) : '0;
  wire [AFF_FIELD_W-1:0] tie2 = (AFF2_W > 0) ?
    AFF_FIELD_W'(level_two_aff_tieoff[sel_phys*T2W +: T2W]) : '0;
  wire [AFF_FIELD_W-1:0] tie3 = (AFF3_W > 0) ?
    AFF_FIELD_W'(level_three_aff_tieoff[sel_phys*T3W +: T3W]) : '0;
  wire aff_type strap_aff = '{level3: tie3, level2: tie2, level1: tie1, level0: tie0};
  // Programmable build: slot k defaults to the affinity of slot k; a removal write drops programmed values
  wire [31:0] slot_ext = 32'(sel);
  wire [31:0] slot_hi = slot_ext >> AFF0_W;
  wire [31:0] slot_lo = slot_ext & ((32'h1 << AFF0_W) - 32'h1);
  wire aff_type slot_aff = '{level3: '0, level2: '0,
                             level1: AFF_FIELD_W'(slot_hi),
                             level0: AFF_FIELD_W'(slot_lo)};
  wire aff_type default_aff = prog_path ? slot_aff : strap_aff;
  wire aff_type sel_aff = written[sel] ? ram_rdata : default_aff;

  wire aff_we = wr_done & hit_aff & remap_ok & sel_in_range;
  wire remove_we = wr_done & hit_remove & remap_ok;

  aff_ram #(
    .DEPTH(NUM_CORES),
    .AW(IDXW)
  ) u_aff_ram (
    .pclk(pclk),
    .presetn(presetn),
    .we(aff_we),
    .waddr(sel),
    .wdata(aff_type'(pwdata)),
    .raddr(sel),
    .rdata(ram_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Read mux
  logic [31:0] read_word;
  logic [NUM_CORES+REMOVE_WORD_BITS-1:0] removed_ext;
  assign removed_ext = {{REMOVE_WORD_BITS{1'b0}}, removed};

  always_comb begin
    read_word = '0;
    if (hit_ctrl) begin
      read_word = ctrl;
    end else if (hit_cfg) begin
      read_word[CAPABLE_BIT] = prog_path;
      read_word[VIEW_BIT] = MULTI_VIEW;
    end else if (hit_count) begin
      read_word = 32'(remaining_count);
    end else if (hit_aux) begin
      read_word = 32'(aux_page_index);
    end else if (hit_remove) begin
      if (prog_path && ({28'h0, remove_word} * REMOVE_WORD_BITS < NUM_CORES)) begin
        read_word = removed_ext[remove_word*REMOVE_WORD_BITS +: REMOVE_WORD_BITS];
      end
    end else if (hit_sel) begin
      read_word = 32'(sel);
    end else if (hit_aff) begin
      read_word = sel_aff;
    end else if (hit_type) begin
      read_word[FINAL_BIT] = sel_is_final;
      read_word[PPI_LSB +: 8] = ppi_count_tieoff;
      read_word[PROC_LSB +: IDXW] = sel;
    end else if (hit_errrec) begin
      read_word = err_record;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB handshake: one wait cycle so the registered affinity read is ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= access & strap_taken;
      prdata <= (access & ~pwrite) ? read_word : '0;
      pslverr <= access & ~mapped;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      sel <= '0;
    end else begin
      if (wr_done && hit_ctrl && secure_ok && view_ok) begin
        ctrl[SECDIS_BIT] <= pwdata[SECDIS_BIT];
      end
      if (wr_done && hit_sel) begin
        sel <= pwdata[IDXW-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Removal mask: strap sampled once at reset release, or set by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      removed <= '0;
      strap_taken <= 1'b0;
      written <= '0;
    end else begin
      strap_taken <= 1'b1;
      if (!strap_taken && !prog_path) begin
        removed <= core_remove_tieoff;
      end
      if (remove_we) begin
        for (int i = 0; i < NUM_CORES; i++) begin
          if (i / REMOVE_WORD_BITS == int'(remove_word) &&
              pwdata[i % REMOVE_WORD_BITS]) begin
            removed[i] <= 1'b1;
          end
        end
        written <= '0;
      end else if (aff_we) begin
        written[sel] <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Compacted map outputs and routing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remaining_count <= (IDXW+1)'(NUM_CORES);
      aux_page_index <= (IDXW+1)'(NUM_CORES);
      route_phys_core <= '0;
    end else begin
      remaining_count <= next_count;
      aux_page_index <= next_count;
      route_phys_core <= sel_phys;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Error insertion and RAM error records, available cores only
  // Self-test paths do not pass through this block and are left as built
  wire errins_ok = wr_done & hit_errins & sel_in_range & ~removed[sel_phys];
  wire ram_err_ok = ram_err_valid & ~removed[ram_err_core];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_inject_valid <= 1'b0;
      err_inject_core <= '0;
      err_inject_data <= '0;
      err_record <= '0;
    end else begin
      err_inject_valid <= errins_ok;
      if (errins_ok) begin
        err_inject_core <= sel_phys;
        err_inject_data <= pwdata;
      end
      if (ram_err_ok) begin
        err_record <= '0;
        err_record[ERRREC_VALID_BIT] <= 1'b1;
        err_record[IDXW-1:0] <= ram_err_core;
      end else if (done && !pwrite && hit_errrec) begin
        err_record <= '0;
      end
    end
  end

endmodule : core_removal_remap

//--- core_removal_remap_tb_top.sv
// Self-checking bench for core removal and redistributor remap
`timescale 1ns/1ps
module core_removal_remap_tb_top;
  import core_removal_pkg::*;
  localparam int NC = 16;
  localparam logic [7:0] PPI = 8'h1b;
  logic pclk, presetn, psel, penable, pwrite, fire, pready, pslverr, err_inject_valid;
  logic ram_err_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd, err_inject_data;
  logic [2:0] pprot;
  logic [1:0] access_view;
  logic [3:0] fire_core, route_phys_core, err_inject_core, ram_err_core;
  logic [4:0] remaining_count, aux_page_index;
  logic [NC-1:0] strap_off, l3;
  logic [2*NC-1:0] l0, l1, l2;
  logic [7:0] ppi;
  logic [32:0] rd_q[$];
  logic [32:0] sd_q[$];
  logic s_pready, s_pslverr;
  logic [31:0] s_prdata;
  logic [4:0] s_count, s_aux;
  logic [3:0] s_route;
  logic [35:0] inj_q[$];
  int mismatches, tests_run, strap_core;

  core_removal_remap #(.PATH(REMOVE_BY_PROG), .NUM_CORES(NC)) i_dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pprot(pprot), .access_view(access_view), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_remove_tieoff(strap_off),
    .level_zero_aff_tieoff(l0), .level_one_aff_tieoff(l1), .level_two_aff_tieoff(l2),
    .level_three_aff_tieoff(l3), .ppi_count_tieoff(ppi), .ram_err_valid(ram_err_valid),
    .ram_err_core(ram_err_core), .remaining_count(remaining_count),
    .aux_page_index(aux_page_index), .route_phys_core(route_phys_core),
    .err_inject_valid(err_inject_valid), .err_inject_core(err_inject_core),
    .err_inject_data(err_inject_data));
  removal_partner #(.NUM_CORES(NC), .PPI_COUNT(PPI)) i_partner (.pclk(pclk), .fire(fire),
    .fire_core(fire_core), .core_remove_tieoff(strap_off), .level_zero_aff_tieoff(l0),
    .level_one_aff_tieoff(l1), .level_two_aff_tieoff(l2), .level_three_aff_tieoff(l3),
    .ppi_count_tieoff(ppi), .ram_err_valid(ram_err_valid), .ram_err_core(ram_err_core));
  // Strap build with views, on the same bus and tie-offs
  core_removal_remap #(.PATH(REMOVE_BY_STRAP), .MULTI_VIEW(1'b1), .NUM_CORES(NC)) i_dut_strap (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pprot(pprot), .access_view(access_view),
    .prdata(s_prdata), .pready(s_pready), .pslverr(s_pslverr), .core_remove_tieoff(strap_off),
    .level_zero_aff_tieoff(l0), .level_one_aff_tieoff(l1), .level_two_aff_tieoff(l2),
    .level_three_aff_tieoff(l3), .ppi_count_tieoff(ppi), .ram_err_valid(ram_err_valid),
    .ram_err_core(ram_err_core), .remaining_count(s_count), .aux_page_index(s_aux),
    .route_phys_core(s_route), .err_inject_valid(), .err_inject_core(),
    .err_inject_data());

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test;
    if (mismatches == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  // Default affinity of a compacted slot in the programmable build
  function automatic logic [31:0] aff_def(input int k);
    return {16'h0, 8'(k >> 2), 8'(k & 3)};
  endfunction : aff_def

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dt,
                     input logic ns);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dt;
    pprot <= {1'b0, ns, 1'b0};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [32:0] exp);
    rd_q.push_back(exp);
    apb(1'b0, a, 32'h0, 1'b0);
  endtask : rd

  task automatic fire_err(input logic [3:0] c);
    @(posedge pclk);
    fire <= 1'b1;
    fire_core <= c;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : fire_err

  // Result watcher: each read answer or insert pulse consumes the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check("read data", {3'b0, pslverr, prdata}, {3'b0, rd_q.pop_front()});
    end
    if (psel && penable && pready === 1'b1 && !pwrite && sd_q.size() > 0) begin
      check("strap read", {3'b0, s_pslverr, s_prdata}, {3'b0, sd_q.pop_front()});
    end
    if (err_inject_valid === 1'b1) begin
      check("error insert", {err_inject_core, err_inject_data}, inj_q.pop_front());
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #(5000 * 10);
    mismatches++;
    stop_test();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, fire} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pprot = 3'h0;
    access_view = 2'b00;
    fire_core = 4'h0;
    rnd = 32'hbd4f;
    mismatches = 0;
    tests_run = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    check("count at reset", 36'(remaining_count), 36'(NC));
    check("strap count", 36'(s_count), 36'(NC - 2));
    check("strap aux page", 36'(s_aux), 36'(NC - 2));
    sd_q.push_back(33'h2);
    rd(CFG_OFS, 33'h1);
    apb(1'b1, REMOVE_FIRST_OFS, 32'h1, 1'b1);
    repeat (3) @(posedge pclk);
    check("count after non-secure", 36'(remaining_count), 36'(NC));
    rnd = xs(rnd);
    apb(1'b1, SEL_OFS, 32'h3, 1'b0);
    apb(1'b1, AFF_OFS, rnd, 1'b0);
    rd(AFF_OFS, {1'b0, rnd});
    apb(1'b1, REMOVE_FIRST_OFS, 32'h2, 1'b0);
    repeat (3) @(posedge pclk);
    check("count after removal", 36'(remaining_count), 36'(NC - 1));
    check("aux page", 36'(aux_page_index), 36'(NC - 1));
    rd(REMOVE_FIRST_OFS, 33'h2);
    rd(COUNT_OFS, 33'(NC - 1));
    rd(AFF_OFS, {1'b0, aff_def(3)});
    for (int k = 0; k < NC - 1; k++) begin
      strap_core = (k < 1) ? 1 : (k < 2) ? 3 : k + 2;
      apb(1'b1, SEL_OFS, 32'(k), 1'b0);
      if (k < NC - 2) begin
        sd_q.push_back({1'b0, aff_def(strap_core)});
      end
      rd(AFF_OFS, {1'b0, aff_def(k)});
      if (k < NC - 2) begin
        sd_q.push_back({1'b0, 32'(k) << PROC_LSB | 32'(PPI) << PPI_LSB |
                        32'(k == NC - 3)});
      end
      rd(TYPE_OFS, {1'b0, 32'(k) << PROC_LSB | 32'(PPI) << PPI_LSB | 32'(k == NC - 2)});
      check("routed core", 36'(route_phys_core), 36'((k < 1) ? k : k + 1));
      if (k < NC - 2) begin
        check("strap route", 36'(s_route), 36'(strap_core));
      end
    end
    rnd = xs(rnd);
    inj_q.push_back({4'd15, rnd});
    apb(1'b1, ERRINS_OFS, rnd, 1'b0);
    fire_err(4'd1);
    sd_q.push_back(33'h0_8000_0001);
    rd(ERRREC_OFS, 33'h0);
    fire_err(4'd3);
    sd_q.push_back(33'h0_8000_0003);
    rd(ERRREC_OFS, 33'h0_8000_0003);
    access_view <= 2'b01;
    apb(1'b1, CTRL_OFS, 32'h1, 1'b0);
    access_view <= 2'b00;
    sd_q.push_back(33'h0);
    rd(CTRL_OFS, 33'h1);
    apb(1'b1, REMOVE_FIRST_OFS, 32'h8, 1'b1);
    repeat (3) @(posedge pclk);
    check("count after second removal", 36'(remaining_count), 36'(NC - 2));
    sd_q.push_back(33'h0);
    rd(REMOVE_FIRST_OFS, 33'ha);
    rd(12'h200, 33'h1_0000_0000);
    repeat (5) @(posedge pclk);
    stop_test();
  end
endmodule : core_removal_remap_tb_top

bind core_removal_remap removal_checker #(.NUM_CORES(NUM_CORES)) i_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pprot(pprot), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .remaining_count(remaining_count), .aux_page_index(aux_page_index),
  .err_inject_valid(err_inject_valid));

//--- removal_checker.sv
// Concurrent checks on the ports of the core removal block
`timescale 1ns/1ps
module removal_checker
  import core_removal_pkg::*;
#(
  parameter int NUM_CORES = 16,
  localparam int IDXW = (NUM_CORES > 1) ? $clog2(NUM_CORES) : 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] pprot,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Remap results
  input wire logic [IDXW:0] remaining_count,
  input wire logic [IDXW:0] aux_page_index,
  input wire logic err_inject_valid
);
  logic sec_dis;
  wire done = psel && penable && pready;
  wire rem_hit = paddr >= REMOVE_FIRST_OFS && paddr <= REMOVE_LAST_OFS;
  wire low_hit = paddr <= AUX_OFS || (paddr >= SEL_OFS && paddr <= ERRREC_OFS);
  wire mapped = (rem_hit || low_hit) && paddr[1:0] == 2'b00;
  wire errins_wr = done && pwrite && paddr == ERRINS_OFS;
  wire nonsec_rem = done && pwrite && rem_hit && pprot[PPROT_NONSEC_BIT] && !sec_dis;

  // Shadow of the security-disable control, same secure check as the block but no view check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_dis <= 1'b0;
    end else if (done && pwrite && paddr == CTRL_OFS &&
                 (!pprot[PPROT_NONSEC_BIT] || sec_dis)) begin
      sec_dis <= pwdata[SECDIS_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not after exactly one wait state");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_read_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("prdata not zero outside a read answer");
  chk_unmapped_err: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match the address map");
  chk_aux_above: assert property (aux_page_index == remaining_count)
    else $error("aux page not directly above last redistributor");
  chk_count_monotone: assert property (remaining_count <= $past(remaining_count))
    else $error("remaining count grew without reset");
  chk_nonsec_ignored: assert property (nonsec_rem |=> $stable(remaining_count) [*3])
    else $error("non-secure removal took effect");
  chk_err_cause: assert property (err_inject_valid |-> $past(errins_wr))
    else $error("error insert pulse without an insert write");
  chk_err_pulse: assert property (err_inject_valid |=> !err_inject_valid)
    else $error("error insert pulse too long");

  cov_removal: cover property (done && pwrite && rem_hit);
  cov_inject: cover property (err_inject_valid);
  cov_slverr: cover property (pready && pslverr);
endmodule : removal_checker

//--- removal_partner.sv
// Integrator tie-offs and cluster RAM error source
`timescale 1ns/1ps
module removal_partner #(
  parameter int NUM_CORES = 16,
  parameter int AW = 2,
  parameter logic [7:0] PPI_COUNT = 8'h1b
) (
  // Clock
  input wire logic pclk,
  // Error request from the bench
  input wire logic fire,
  input wire logic [3:0] fire_core,
  // Tie-offs
  output logic [NUM_CORES-1:0] core_remove_tieoff,
  output logic [NUM_CORES*AW-1:0] level_zero_aff_tieoff,
  output logic [NUM_CORES*AW-1:0] level_one_aff_tieoff,
  output logic [NUM_CORES*AW-1:0] level_two_aff_tieoff,
  output logic [NUM_CORES-1:0] level_three_aff_tieoff,
  output logic [7:0] ppi_count_tieoff,
  // RAM error report
  output logic ram_err_valid,
  output logic [3:0] ram_err_core
);
  // Constant from time zero, never every bit set
  assign core_remove_tieoff = NUM_CORES'(5);
  // Slice k carries core k: level 0 is k mod 4, level 1 is k / 4
  always_comb begin
    for (int k = 0; k < NUM_CORES; k++) begin
      level_zero_aff_tieoff[k*AW +: AW] = AW'(k % 4);
      level_one_aff_tieoff[k*AW +: AW] = AW'(k / 4);
    end
  end
  assign level_two_aff_tieoff = '0;
  assign level_three_aff_tieoff = '0;
  assign ppi_count_tieoff = PPI_COUNT;

  // Core field is scrambled when no report is valid
  // RAM error reports only; no core sends stream messages
  always_ff @(posedge pclk) begin
    ram_err_valid <= fire;
    ram_err_core <= fire ? fire_core : ~ram_err_core;
  end
endmodule : removal_partner
